// *** include/sfb_defines.svh ***
// Constants for the multi-IO serial flash bus state block
// Overview of operation
// [R01] Single output drives SO, ignores SI, WP
// [R02] Output phases last until select rises
// [R03] Dual IO address, mode: two bits/clock
// [R04] Dual: latency if nonzero, else output
// [R05] Latency count equals configured latency code
// [R06] SDR latency: no sampling, no driving
// [R07] Host releases IO by last latency fall
// [R08] Dual output: two bits per clock
// [R09] Quad input four bits; four-line too
// [R10] Four-line program ends at select rise
// [R11] Quad IO: latency if set, else output
// [R12] Quad output: four bits per clock
// [R13] DDR address both edges, then latency
// [R14] DDR output: nibble per edge
// [R15] Host never drives during DDR latency
// [R16] Learning pattern only last four cycles
// [R17] Software: pattern off below five cycles
// [R18] Configured latency for most read commands
// [R19] Basic read zero, parameter read eight
// [R20] Quad enable gates quad, DDR, four-line
// [R21] Misaligned modifying commands silently ignored
// [R22] Deep sleep accepts only release command
// [R23] No command accepted during power-on reset
// [R24] Config two bit six: four-line instructions
// [R25] Select high: standby; low: new instruction
// [R26] Deep sleep entry only when not busy
// [R27] SDR output changes after falling edge
`ifndef SFB_DEFINES_SVH
`define SFB_DEFINES_SVH
`define SFB_OP_READ 8'h03
`define SFB_OP_FAST 8'h0b
`define SFB_OP_DUAL_OUT 8'h3b
`define SFB_OP_DUAL_IO 8'hbb
`define SFB_OP_QUAD_OUT 8'h6b
`define SFB_OP_QUAD_IO 8'heb
`define SFB_OP_DDR_QUAD 8'hed
`define SFB_OP_PARAM 8'h5a
`define SFB_OP_OTP 8'h4b
`define SFB_OP_ECC 8'h18
`define SFB_OP_ANYREG 8'h65
`define SFB_OP_PROG 8'h02
`define SFB_OP_QPROG 8'h32
`define SFB_OP_ERASE_SEC 8'h20
`define SFB_OP_ERASE_BLK 8'hd8
`define SFB_OP_ERASE_CHIP 8'hc7
`define SFB_OP_WRITE_REG 8'h01
`define SFB_OP_SLEEP 8'hb9
`define SFB_OP_WAKE 8'hab
`define SFB_QE_BIT 1
`define SFB_FOUR_BIT 6
`define SFB_LAT_HI 3
`define SFB_BUSY_BIT 0
`define SFB_CMD_BITS 6'h08
`define SFB_ADDR_BITS 6'h18
`define SFB_AMODE_BITS 6'h20
`define SFB_LAT_PARAM 4'h8
`define SFB_LEARN_CYC 4'h4
`define SFB_TPU_US 300
`define SFB_CLK_MHZ 10
`define SFB_TPU_CYC (`SFB_TPU_US * `SFB_CLK_MHZ)
`define SFB_NO_DRIVE 4'hf
`define SFB_CS_IDLE 1'b1
`endif

// *** include/sfb_pkg.sv ***
// Types and command decoding for the serial flash bus state block
`include "sfb_defines.svh"
package sfb_pkg;
  typedef enum logic [5:0] {
    SFB_ST_CMD = 6'h01,
    SFB_ST_ADDR = 6'h02,
    SFB_ST_LAT = 6'h04,
    SFB_ST_OUT = 6'h08,
    SFB_ST_DIN = 6'h10,
    SFB_ST_IGN = 6'h20
  } sfb_state_t;

  typedef enum logic [1:0] {
    SFB_LAT_NONE = 2'h0,
    SFB_LAT_CFG = 2'h1,
    SFB_LAT_FIXED = 2'h2
  } sfb_lat_t;

  typedef struct packed {
    logic has_addr;
    logic mode;
    logic rd;
    logic ddr;
    logic quad;
    logic modify;
    logic [2:0] aw;
    logic [2:0] ow;
    logic [2:0] dw;
    sfb_lat_t lat_sel;
  } sfb_fmt_t;

  typedef struct packed {
    logic ready;
    logic deep;
    logic qe;
    logic four;
    logic learn;
    logic [3:0] lat;
    logic [7:0] pat;
    logic [7:0] rdata;
  } sfb_cfg_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
  } sfb_cmd_t;

  // Transfer format of a command
  function automatic sfb_fmt_t sfb_fmt_of(input logic [7:0] op, input logic four);
    sfb_fmt_t f;
    f = '{has_addr: 1'b1, mode: 1'b0, rd: 1'b1, ddr: 1'b0, quad: 1'b0, modify: 1'b0,
          aw: 3'h1, ow: 3'h1, dw: 3'h1, lat_sel: SFB_LAT_CFG};
    case (op)
      `SFB_OP_READ: f.lat_sel = SFB_LAT_NONE;
      `SFB_OP_PARAM: f.lat_sel = SFB_LAT_FIXED;
      `SFB_OP_FAST, `SFB_OP_OTP, `SFB_OP_ECC, `SFB_OP_ANYREG: f.lat_sel = SFB_LAT_CFG;
      `SFB_OP_DUAL_OUT: f.ow = 3'h2;
      `SFB_OP_DUAL_IO: begin
        f.aw = 3'h2;
        f.ow = 3'h2;
        f.mode = 1'b1;
      end
      `SFB_OP_QUAD_OUT: begin
        f.ow = 3'h4;
        f.quad = 1'b1;
      end
      `SFB_OP_QUAD_IO, `SFB_OP_DDR_QUAD: begin
        f.aw = 3'h4;
        f.ow = 3'h4;
        f.mode = 1'b1;
        f.quad = 1'b1;
        f.ddr = (op == `SFB_OP_DDR_QUAD);
      end
      `SFB_OP_PROG, `SFB_OP_ERASE_SEC, `SFB_OP_ERASE_BLK: begin
        f.rd = 1'b0;
        f.modify = 1'b1;
      end
      `SFB_OP_QPROG: begin
        f.rd = 1'b0;
        f.modify = 1'b1;
        f.quad = 1'b1;
        f.dw = 3'h4;
      end
      `SFB_OP_ERASE_CHIP, `SFB_OP_WRITE_REG: begin
        f.has_addr = 1'b0;
        f.rd = 1'b0;
        f.modify = 1'b1;
      end
      default: begin
        f.has_addr = 1'b0;
        f.rd = 1'b0;
      end
    endcase
    if (four) begin
      f.aw = 3'h4;
      f.ow = 3'h4;
      f.dw = 3'h4;
    end
    return f;
  endfunction
endpackage

// *** logic/sfb_bus_states.sv ***
// Bus-side phase sequencing of a multi-IO serial flash
module sfb_bus_states (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  input wire logic [7:0] volatile_config_one,
  input wire logic [7:0] volatile_config_two,
  input wire logic [7:0] volatile_status_one,
  input wire logic learning_pattern_en,
  input wire logic [7:0] learning_pattern,
  input wire logic [7:0] read_data,
  output logic cmd_valid,
  output sfb_pkg::sfb_cmd_t cmd,
  output logic deep_sleep,
  output logic if_ready
);

  // Shift new input bits in at the given width
  function automatic logic [31:0] shin(input logic [31:0] v, input logic [3:0] io, input logic [2:0] w);
    case (w)
      3'h2: shin = {v[29:0], io[1:0]};
      3'h4: shin = {v[27:0], io};
      default: shin = {v[30:0], io[0]};
    endcase
  endfunction

  // Lanes driven for an output width
  function automatic logic [3:0] lanes(input logic [2:0] w);
    case (w)
      3'h2: lanes = 4'h3;
      3'h4: lanes = 4'hf;
      default: lanes = 4'h2;
    endcase
  endfunction

  // Output bits of the data byte at a bit pointer
  function automatic logic [3:0] pick(input logic [7:0] b, input logic [2:0] ptr, input logic [2:0] w);
    logic [7:0] s;
    s = b << ptr;
    case (w)
      3'h2: pick = {2'h0, s[7:6]};
      3'h4: pick = s[7:4];
      default: pick = {2'h0, s[7], 1'b0};
    endcase
  endfunction

  // Rising and falling nibbles merged in transfer order
  function automatic logic [31:0] merge(input logic [15:0] p, input logic [15:0] n);
    merge = {p[15:12], n[15:12], p[11:8], n[11:8], p[7:4], n[7:4], p[3:0], n[3:0]};
  endfunction

  // System clock domain
  logic [11:0] por_cnt_r;
  logic ready_r;
  logic deep_r;
  logic cs_m_r;
  logic cs_s_r;
  logic cs_d_r;
  logic seen_r;
  logic frame_end;
  logic accept;
  sfb_pkg::sfb_fmt_t end_fmt;
  sfb_pkg::sfb_cfg_t cfg_src;

  // Link clock domain
  sfb_pkg::sfb_cfg_t cfg_m_r;
  sfb_pkg::sfb_cfg_t cfg_s_r;
  sfb_pkg::sfb_state_t st_r;
  sfb_pkg::sfb_state_t st_nxt;
  sfb_pkg::sfb_fmt_t fmt_r;
  sfb_pkg::sfb_fmt_t fmt_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] step;
  logic [5:0] abits;
  logic [7:0] opcode_r;
  logic [7:0] op_nxt;
  logic [31:0] op_wide;
  logic [31:0] addr_r;
  logic [15:0] apos_r;
  logic [15:0] aneg_r;
  logic [2:0] tot_r;
  logic frm_tgl_r;
  logic [3:0] lat_r;
  logic [3:0] lat_eff;
  logic [3:0] lat_cnt_r;
  logic [3:0] lat_m1;
  logic cmd_done;
  logic learn_on;
  logic [3:0] out_n_r;
  logic [3:0] drv_n_r;
  logic [3:0] out_p_r;
  logic [3:0] drv_p_r;
  logic [2:0] ptr_r;
  logic sel_p;

  // Power-on reset wait
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      por_cnt_r <= 12'h000;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      por_cnt_r <= por_cnt_r + 12'h001;
      ready_r <= (por_cnt_r == 12'(`SFB_TPU_CYC - 1)); // [R23]
    end
  end

  // Select synchroniser and frame end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_m_r <= `SFB_CS_IDLE;
      cs_s_r <= `SFB_CS_IDLE;
      cs_d_r <= `SFB_CS_IDLE;
    end else begin
      cs_m_r <= cs_n;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
    end
  end

  assign frame_end = cs_s_r & ~cs_d_r;
  assign end_fmt = sfb_pkg::sfb_fmt_of(opcode_r, 1'b0);

  // Command acceptance after the frame has closed
  always_comb begin
    accept = frame_end && ready_r && (frm_tgl_r != seen_r); // [R23]
    if (deep_r && opcode_r != `SFB_OP_WAKE) begin
      accept = 1'b0; // [R22]
    end
    if (end_fmt.modify && tot_r != 3'h0) begin
      accept = 1'b0; // [R21]
    end
    if ((end_fmt.quad || volatile_config_two[`SFB_FOUR_BIT]) && !volatile_config_one[`SFB_QE_BIT]) begin
      accept = 1'b0; // [R20]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_r <= 1'b0;
      cmd_valid <= 1'b0;
      cmd <= '0;
    end else begin
      cmd_valid <= accept;
      if (frame_end) begin
        seen_r <= frm_tgl_r;
      end
      if (accept) begin
        cmd.opcode <= opcode_r;
        cmd.addr <= end_fmt.ddr ? merge(apos_r, aneg_r) : addr_r;
      end
    end
  end

  // Deep sleep state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      deep_r <= 1'b0;
    end else if (accept && opcode_r == `SFB_OP_SLEEP && !volatile_status_one[`SFB_BUSY_BIT]) begin
      deep_r <= 1'b1; // [R26]
    end else if (accept && opcode_r == `SFB_OP_WAKE) begin
      deep_r <= 1'b0; // [R22]
    end
  end

  assign deep_sleep = deep_r;
  assign if_ready = ready_r;

  assign cfg_src = '{ready: ready_r, deep: deep_r, qe: volatile_config_one[`SFB_QE_BIT],
                     four: volatile_config_two[`SFB_FOUR_BIT], learn: learning_pattern_en,
                     lat: volatile_config_two[`SFB_LAT_HI:0], pat: learning_pattern, rdata: read_data};

  // Settings into the link domain
  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_m_r <= '0;
      cfg_s_r <= '0;
    end else begin
      cfg_m_r <= cfg_src;
      cfg_s_r <= cfg_m_r;
    end
  end

  // Bits per rising edge in each phase
  always_comb begin
    case (st_r)
      sfb_pkg::SFB_ST_CMD: step = cfg_s_r.four ? 6'h04 : 6'h01; // [R24] [R09]
      sfb_pkg::SFB_ST_ADDR: step = fmt_r.ddr ? 6'h08 : {3'h0, fmt_r.aw}; // [R03] [R09] [R13]
      sfb_pkg::SFB_ST_DIN: step = {3'h0, fmt_r.dw}; // [R09]
      default: step = 6'h00;
    endcase
  end

  assign cnt_nxt = cnt_r + step;
  assign op_wide = shin({24'h0, opcode_r}, io_in, cfg_s_r.four ? 3'h4 : 3'h1);
  assign op_nxt = op_wide[7:0];
  assign fmt_nxt = sfb_pkg::sfb_fmt_of(op_nxt, cfg_s_r.four);
  assign cmd_done = (st_r == sfb_pkg::SFB_ST_CMD) && (cnt_nxt == `SFB_CMD_BITS);
  assign abits = fmt_r.mode ? `SFB_AMODE_BITS : `SFB_ADDR_BITS;
  assign lat_m1 = lat_cnt_r - 4'h1;

  // Latency for the command just received
  always_comb begin
    case (fmt_nxt.lat_sel)
      sfb_pkg::SFB_LAT_NONE: lat_eff = 4'h0; // [R19]
      sfb_pkg::SFB_LAT_FIXED: lat_eff = `SFB_LAT_PARAM; // [R19]
      default: lat_eff = cfg_s_r.lat; // [R05] [R18]
    endcase
    if (fmt_nxt.ddr && lat_eff == 4'h0) begin
      lat_eff = 4'h1; // [R13]
    end
  end

  // Phase sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      sfb_pkg::SFB_ST_CMD: begin
        if (cmd_done) begin
          if (!cfg_s_r.ready || (cfg_s_r.deep && op_nxt != `SFB_OP_WAKE)) begin
            st_nxt = sfb_pkg::SFB_ST_IGN; // [R23] [R22]
          end else if ((fmt_nxt.quad || cfg_s_r.four) && !cfg_s_r.qe) begin
            st_nxt = sfb_pkg::SFB_ST_IGN; // [R20]
          end else if (fmt_nxt.has_addr) begin
            st_nxt = sfb_pkg::SFB_ST_ADDR;
          end else begin
            st_nxt = sfb_pkg::SFB_ST_DIN;
          end
        end
      end
      sfb_pkg::SFB_ST_ADDR: begin
        if (cnt_nxt == abits) begin
          if (!fmt_r.rd) begin
            st_nxt = sfb_pkg::SFB_ST_DIN;
          end else if (lat_r == 4'h0) begin
            st_nxt = sfb_pkg::SFB_ST_OUT; // [R04] [R11]
          end else begin
            st_nxt = sfb_pkg::SFB_ST_LAT; // [R04] [R11] [R13]
          end
        end
      end
      sfb_pkg::SFB_ST_LAT: begin
        if (lat_cnt_r == 4'h1) begin
          st_nxt = sfb_pkg::SFB_ST_OUT; // [R05]
        end
      end
      default: st_nxt = st_r; // [R02] [R10]
    endcase
  end

  // State and phase bit count; select high is standby
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      st_r <= sfb_pkg::SFB_ST_CMD; // [R25] [R10]
      cnt_r <= 6'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 6'h00 : cnt_nxt;
    end
  end

  // Command capture; frame toggle marks a complete instruction
  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      frm_tgl_r <= 1'b0;
    end else if (cmd_done) begin
      frm_tgl_r <= ~frm_tgl_r;
    end
  end

  always_ff @(posedge sck) begin
    if (st_r == sfb_pkg::SFB_ST_CMD) begin
      opcode_r <= op_nxt;
    end
    if (cmd_done) begin
      fmt_r <= fmt_nxt;
      lat_r <= lat_eff;
    end
  end

  // Address and mode bits
  always_ff @(posedge sck) begin
    if (cmd_done) begin
      addr_r <= 32'h0;
    end else if (st_r == sfb_pkg::SFB_ST_ADDR && fmt_r.ddr) begin
      apos_r <= {apos_r[11:0], io_in}; // [R13]
    end else if (st_r == sfb_pkg::SFB_ST_ADDR) begin
      addr_r <= shin(addr_r, io_in, fmt_r.aw); // [R03] [R09]
    end
  end

  always_ff @(negedge sck) begin
    if (fmt_r.ddr && ((st_r == sfb_pkg::SFB_ST_ADDR && cnt_r != 6'h00) ||
                      (st_r == sfb_pkg::SFB_ST_LAT && lat_cnt_r == lat_r))) begin
      aneg_r <= {aneg_r[11:0], io_in}; // [R13]
    end
  end

  // Bit total modulo a byte for the alignment check
  always_ff @(posedge sck) begin
    if (st_r == sfb_pkg::SFB_ST_CMD && cnt_r == 6'h00) begin
      tot_r <= step[2:0];
    end else begin
      tot_r <= tot_r + step[2:0]; // [R21]
    end
  end

  // Latency countdown
  always_ff @(posedge sck) begin
    if (st_r == sfb_pkg::SFB_ST_ADDR) begin
      lat_cnt_r <= lat_r;
    end else if (st_r == sfb_pkg::SFB_ST_LAT) begin
      lat_cnt_r <= lat_m1; // [R05]
    end
  end

  assign learn_on = (st_r == sfb_pkg::SFB_ST_LAT) && fmt_r.ddr && cfg_s_r.learn &&
                    (lat_cnt_r <= `SFB_LEARN_CYC) && (lat_cnt_r != 4'h0);

  // Falling-edge launch: SDR data, DDR high nibble, pattern
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_n_r <= 4'h0;
      drv_n_r <= `SFB_NO_DRIVE;
      ptr_r <= 3'h0;
    end else if (st_r == sfb_pkg::SFB_ST_OUT && fmt_r.ddr) begin
      out_n_r <= cfg_s_r.rdata[7:4]; // [R14]
      drv_n_r <= 4'h0;
    end else if (st_r == sfb_pkg::SFB_ST_OUT) begin
      out_n_r <= pick(cfg_s_r.rdata, ptr_r, fmt_r.ow); // [R01] [R08] [R12] [R27]
      drv_n_r <= ~lanes(fmt_r.ow); // [R01] [R08] [R12]
      ptr_r <= ptr_r + fmt_r.ow; // [R02]
    end else if (learn_on) begin
      out_n_r <= {4{cfg_s_r.pat[{lat_m1[1:0], 1'b1}]}}; // [R16]
      drv_n_r <= 4'h0; // [R16]
    end else begin
      drv_n_r <= `SFB_NO_DRIVE; // [R06] [R15]
    end
  end

  // Rising-edge launch: DDR low nibble and pattern
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_p_r <= 4'h0;
      drv_p_r <= `SFB_NO_DRIVE;
    end else if (st_r == sfb_pkg::SFB_ST_OUT && fmt_r.ddr) begin
      out_p_r <= cfg_s_r.rdata[3:0]; // [R14]
      drv_p_r <= 4'h0;
    end else if (learn_on) begin
      out_p_r <= {4{cfg_s_r.pat[{lat_m1[1:0], 1'b0}]}}; // [R16]
      drv_p_r <= 4'h0;
    end else begin
      drv_p_r <= `SFB_NO_DRIVE;
    end
  end

  assign sel_p = fmt_r.ddr & sck & ~cs_n;
  assign io_out = sel_p ? out_p_r : out_n_r;
  assign io_oe_n = sel_p ? drv_p_r : drv_n_r;

endmodule // sfb_bus_states

// *** tb/sfb_bus_monitor.sv ***
// Port-level concurrent checks for the serial flash bus state block
`include "sfb_defines.svh"
module sfb_bus_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  input wire logic [7:0] volatile_config_one,
  input wire logic [7:0] volatile_config_two,
  input wire logic [7:0] volatile_status_one,
  input wire logic learning_pattern_en,
  input wire logic [7:0] learning_pattern,
  input wire logic [7:0] read_data,
  input wire logic cmd_valid,
  input wire sfb_pkg::sfb_cmd_t cmd,
  input wire logic deep_sleep,
  input wire logic if_ready
);
  localparam int TPU = `SFB_TPU_CYC;
  logic [12:0] wait_r;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Cycles since reset release until ready
  always_ff @(posedge clk) begin
    if (sys_rst) wait_r <= 13'h0;
    else if (!if_ready) wait_r <= wait_r + 13'h1;
  end
  a_idle_release: assert property (cs_n |-> io_oe_n == 4'hf)
    else $error("IO driven while deselected");
  a_pulse_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  a_frame_closed: assert property (cmd_valid |-> cs_n && $past(cs_n, 2))
    else $error("command taken before select rose");
  a_ready_first: assert property (!if_ready |-> !cmd_valid && io_oe_n == 4'hf)
    else $error("activity before power-on wait ended");
  a_ready_time: assert property ($rose(if_ready) |-> wait_r >= TPU - 3 && wait_r <= TPU + 3)
    else $error("power-on wait length wrong");
  a_sleep_enter: assert property ($rose(deep_sleep) |-> cmd_valid && cmd.opcode == `SFB_OP_SLEEP
    && !volatile_status_one[`SFB_BUSY_BIT]) else $error("deep sleep entered wrongly");
  a_sleep_exit: assert property ($fell(deep_sleep) |-> cmd_valid && cmd.opcode == `SFB_OP_WAKE)
    else $error("deep sleep left without release");
  a_sleep_filter: assert property (cmd_valid && $past(deep_sleep) |-> cmd.opcode == `SFB_OP_WAKE)
    else $error("command accepted in deep sleep");
  a_quad_gate: assert property (cmd_valid && (cmd.opcode inside {8'h6b, 8'heb, 8'hed, 8'h32}
    || volatile_config_two[`SFB_FOUR_BIT]) |-> volatile_config_one[`SFB_QE_BIT]) else $error("quad without enable");
  a_oe_shape: assert property (io_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("unexpected output enable pattern");
  c_accept: cover property (cmd_valid);
  c_sleep: cover property ($rose(deep_sleep));
  c_dual: cover property (io_oe_n == 4'hc);
  c_quad: cover property (io_oe_n == 4'h0);
endmodule // sfb_bus_monitor

bind sfb_bus_states sfb_bus_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .io_in(io_in),
  .io_out(io_out), .io_oe_n(io_oe_n), .volatile_config_one(volatile_config_one),
  .volatile_config_two(volatile_config_two), .volatile_status_one(volatile_status_one),
  .learning_pattern_en(learning_pattern_en), .learning_pattern(learning_pattern), .read_data(read_data),
  .cmd_valid(cmd_valid), .cmd(cmd), .deep_sleep(deep_sleep), .if_ready(if_ready));

// *** tb/sfb_host_model.sv ***
// Host-side serial flash controller model, link mode 0
module sfb_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] host_d,
  output logic [3:0] host_oe,
  input wire logic [3:0] io_wire,
  input wire logic [3:0] dev_oe_n,
  input wire logic qe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    host_d = 4'h0;
    host_oe = 4'h0;
  end
  // One link cycle on w lines, reset and protect lines held high while quad enable is off
  task automatic cyc(input logic [3:0] d, input int w);
    // Lines move just after the falling edge, clear of both sampling edges
    #1;
    host_oe = (4'hf >> (4 - w)) | (qe ? 4'h0 : 4'hc);
    host_d = d | (qe ? 4'h0 : 4'hc);
    #39 sck = 1'b1;
    #40 sck = 1'b0;
  endtask
  // Edges with select high for settings transfer
  task automatic settle();
    repeat (2) cyc(4'h0, 0);
    host_oe = 4'h0;
  endtask
  // One frame: instruction, address, then released cycles
  task automatic frame(input logic [7:0] op, input int cw, input logic [39:0] bits, input int n, input int aw,
                       input int post, input int ow, output int first, output logic [15:0] got);
    first = -1;
    got = 16'h0;
    cs_n = 1'b0;
    for (int i = 0; i < 8; i += cw) begin
      cyc(op[7:4] >> (4 - cw), cw);
      op = op << cw;
    end
    for (int i = 0; i < n; i += aw) begin
      cyc(bits[39:36] >> (4 - aw), aw);
      bits = bits << aw;
    end
    for (int k = 0; k < post; k++) begin
      #1;
      host_oe = qe ? 4'h0 : 4'hc;
      host_d = 4'hc;
      #38;
      if (first < 0 && dev_oe_n != 4'hf) first = k;
      if (first >= 0) got = (got << ow) | 16'(ow == 1 ? io_wire[1] : io_wire & (4'hf >> (4 - ow)));
      #1 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    host_oe = 4'h0;
  endtask
endmodule // sfb_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the serial flash bus state block
`include "sfb_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sck;
  logic cs_n;
  logic [3:0] io_in, io_out, io_oe_n, host_d, host_oe;
  logic [7:0] cfg1 = 8'h00, cfg2 = 8'h00, stat = 8'h00, rdat = 8'h00;
  logic lp_en = 1'b0;
  logic flt = 1'b0;
  logic cmd_valid, deep_sleep, if_ready;
  logic [31:0] adr;
  sfb_pkg::sfb_cmd_t cmd, last_cmd;
  int n_fail = 0, compares = 0, nv = 0;
  integer seed = 32'ha963;
  logic [7:0] rd_ops[7] = '{`SFB_OP_READ, `SFB_OP_FAST, `SFB_OP_OTP, `SFB_OP_ECC, `SFB_OP_ANYREG,
                            `SFB_OP_PARAM, `SFB_OP_DUAL_OUT};
  logic [7:0] q_ops[3] = '{`SFB_OP_QUAD_IO, `SFB_OP_DDR_QUAD, `SFB_OP_QUAD_OUT};
  int mod_n[4] = '{32, 35, 39, 40};
  always #50 clk = ~clk;
  always #20 flt = ~flt;
  always_comb for (int i = 0; i < 4; i++) io_in[i] = !io_oe_n[i] ? io_out[i] : host_oe[i] ? host_d[i] : flt;
  sfb_bus_states uut (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .volatile_config_one(cfg1), .volatile_config_two(cfg2), .volatile_status_one(stat),
    .learning_pattern_en(lp_en), .learning_pattern(rdat), .read_data(rdat), .cmd_valid(cmd_valid), .cmd(cmd),
    .deep_sleep(deep_sleep), .if_ready(if_ready));
  sfb_host_model host (.sck(sck), .cs_n(cs_n), .host_d(host_d), .host_oe(host_oe), .io_wire(io_in),
    .dev_oe_n(io_oe_n), .qe(cfg1[1]));
  always @(posedge clk) if (cmd_valid === 1'b1) begin
    nv <= nv + 1;
    last_cmd <= cmd;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic int exp_lat(input logic [7:0] op, input logic [3:0] code);
    if (op == `SFB_OP_READ) return 0;
    if (op == `SFB_OP_PARAM) return 8;
    if (op == `SFB_OP_DDR_QUAD && code == 4'h0) return 1;
    return code;
  endfunction
  // DDR address when each nibble is held across both edges
  function automatic logic [31:0] ddr_adr(input logic [15:0] v);
    return {{2{v[15:12]}}, {2{v[11:8]}}, {2{v[7:4]}}, {2{v[3:0]}}};
  endfunction
  task automatic set_cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] st);
    @(posedge clk);
    #5;
    cfg1 = c1;
    cfg2 = c2;
    stat = st;
    rdat = 8'($random(seed));
    repeat (4) @(posedge clk);
    host.settle();
  endtask
  // One frame, then acceptance, latency and returned data
  task automatic run(input logic [7:0] op, input int cw, input logic [39:0] bits, input int n, input int aw,
                     input int ow, input bit ok, input bit drv, input logic [31:0] a);
    int lat, first, v0;
    logic [15:0] got;
    lat = exp_lat(op, cfg2[3:0]);
    v0 = nv;
    host.frame(op, cw, bits, n, aw, drv ? lat + 16 / ow : 16, ow, first, got);
    repeat (8) @(posedge clk);
    cmp(nv - v0, ok, "accept count");
    if (ok) cmp(last_cmd.opcode, op, "opcode");
    if (ok && n > 0) cmp(last_cmd.addr, a, "address");
    cmp(first, drv ? lat - (lp_en && op == `SFB_OP_DDR_QUAD ? 4 : 0) : -1, "first driven cycle");
    if (drv) cmp(got, op == `SFB_OP_DDR_QUAD ? {4{rdat[7:4]}} : {rdat, rdat}, "read data");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #5 sys_rst = 1'b0;
    set_cfg(8'h00, 8'h02, 8'h00);
    run(`SFB_OP_FAST, 1, 40'h0, 24, 1, 1, 1'b0, 1'b0, 32'h0);
    for (int i = 0; i < 4000 && if_ready !== 1'b1; i++) @(posedge clk);
    cmp(if_ready, 1'b1, "ready after power-on wait");
    foreach (rd_ops[i]) begin
      adr = 32'($random(seed)) & 32'h00ffffff;
      set_cfg(8'h00, 8'($random(seed)) & 8'h07, 8'h00);
      run(rd_ops[i], 1, {adr[23:0], 16'h0}, 24, 1, rd_ops[i] == `SFB_OP_DUAL_OUT ? 2 : 1, 1, 1, adr);
    end
    for (int j = 0; j < 3; j++) begin
      adr = $random(seed);
      set_cfg(8'h00, j == 0 ? 8'h00 : j == 1 ? 8'h0f : 8'h03, 8'h00);
      run(`SFB_OP_DUAL_IO, 1, {adr, 8'h0}, 32, 2, 2, 1'b1, 1'b1, adr);
    end
    set_cfg(8'h00, 8'h02, 8'h00);
    foreach (q_ops[i]) run(q_ops[i], 1, {adr, 8'h0}, 32, 4, 4, 1'b0, 1'b0, adr);
    foreach (mod_n[i]) run(`SFB_OP_PROG, 1, {adr[23:0], 16'h5a00}, mod_n[i], 1, 1, mod_n[i] % 8 == 0, 0, adr & 32'hffffff);
    run(`SFB_OP_ERASE_CHIP, 1, 40'h0, 3, 1, 1, 1'b0, 1'b0, 32'h0);
    set_cfg(8'h00, 8'h42, 8'h00);
    run(`SFB_OP_FAST, 4, {adr[23:0], 16'h0}, 24, 4, 4, 1'b0, 1'b0, 32'h0);
    for (int j = 0; j < 2; j++) begin
      adr = $random(seed);
      @(posedge clk);
      #5 lp_en = (j == 1);
      set_cfg(8'h02, 8'(j * 5), 8'h00);
      run(`SFB_OP_QUAD_IO, 1, {adr, 8'h0}, 32, 4, 4, 1'b1, 1'b1, adr);
      run(`SFB_OP_DDR_QUAD, 1, {adr[15:0], 24'h0}, 16, 4, 4, 1'b1, 1'b1, ddr_adr(adr[15:0]));
    end
    adr = adr & 32'h00ffffff;
    run(`SFB_OP_QUAD_OUT, 1, {adr[23:0], 16'h0}, 24, 1, 4, 1'b1, 1'b1, adr);
    set_cfg(8'h02, 8'h42, 8'h00);
    run(`SFB_OP_FAST, 4, {adr[23:0], 16'h0}, 24, 4, 4, 1'b1, 1'b1, adr);
    run(`SFB_OP_PROG, 4, {adr[23:0], 16'ha500}, 32, 4, 4, 1'b1, 1'b0, adr);
    set_cfg(8'h00, 8'h02, 8'h01);
    run(`SFB_OP_SLEEP, 1, 40'h0, 0, 1, 1, 1'b1, 1'b0, 32'h0);
    cmp(deep_sleep, 1'b0, "busy blocks deep sleep");
    set_cfg(8'h00, 8'h02, 8'h00);
    run(`SFB_OP_SLEEP, 1, 40'h0, 0, 1, 1, 1'b1, 1'b0, 32'h0);
    cmp(deep_sleep, 1'b1, "deep sleep entered");
    run(`SFB_OP_FAST, 1, {adr[23:0], 16'h0}, 24, 1, 1, 1'b0, 1'b0, adr);
    run(`SFB_OP_PROG, 1, {adr[23:0], 16'h3c00}, 32, 1, 1, 1'b0, 1'b0, adr);
    run(`SFB_OP_WAKE, 1, 40'h0, 0, 1, 1, 1'b1, 1'b0, 32'h0);
    cmp(deep_sleep, 1'b0, "deep sleep left");
    tally_and_finish();
  end
  initial begin
    #2000000;
    n_fail++;
    tally_and_finish();
  end
endmodule // tb_top
